// [common/tcpw_pkg.sv]
// constants, register layouts and shared helpers of the timer block
// What this block does
// - high pulse timer scale 1:2 to 1:256
// - high pulse clock: sub-oscillator or instruction cycle
// - low pulse timer scale 1:2 to 1:256
// - low pulse clock: sub-oscillator or instruction cycle
// - first counter: 8-bit down, preset, readable count
// - first counter reloads preset after its interrupt
// - second counter: 8-bit down, preset, auto reload
// - second counter makes carrier at clock/(preset+1)
// - high pulse timer: 8-bit down, preset, reload
// - output high for (preset+1) timer clocks
// - low pulse timer: 8-bit down, preset, reload
// - output low for (preset+1) timer clocks
// - eight-bit readable writable interrupt enable mask
// - separate 8-bit prescalers, timer and watchdog
// - writing timer counter clears its prescaler
// - clear or sleep command clears watchdog
// - timer counts instruction cycles, osc/2 or osc/4
// - external source counts selected pin edges
// - watchdog runs free, also during sleep
// - enabled watchdog time-out resets the device
// - software enables watchdog at any time
// - unscaled watchdog time-out about 18 ms
// - timer prescale off 1:1, else 1:2..1:256
// - watchdog scale 1:1 up to 1:128
// - edge select 0 rising, 1 falling
// - timer source 0 internal, 1 pin
package tcpw_pkg;
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int WDT_TIMEOUT_MS = 18;
   localparam int WDT_BASE_CYCLES = WDT_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
   localparam int PRE_W = 8;
   localparam int SHIFT_W = 4;
   localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
   localparam logic [1:0] INSTR_FAST_LAST = 2'h1;
   localparam logic [1:0] INSTR_SLOW_LAST = 2'h3;
   localparam logic [7:0] ADDR_TIMER_COUNT = 8'h00;
   localparam logic [7:0] ADDR_TIMER_CTRL = 8'h04;
   localparam logic [7:0] ADDR_WDOG_CTRL = 8'h08;
   localparam logic [7:0] ADDR_CNT_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_PW_CTRL = 8'h10;
   localparam logic [7:0] ADDR_ONE_PRESET = 8'h14;
   localparam logic [7:0] ADDR_TWO_PRESET = 8'h18;
   localparam logic [7:0] ADDR_HIGH_PRESET = 8'h1C;
   localparam logic [7:0] ADDR_LOW_PRESET = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h28;
   localparam logic [7:0] ADDR_RUN_CTRL = 8'h2C;
   localparam logic [7:0] ADDR_WDOG_CMD = 8'h30;
   localparam int IRQ_TIMER = 0;
   localparam int IRQ_EXT0 = 1;
   localparam int IRQ_EXT1 = 2;
   localparam int IRQ_ONE = 3;
   localparam int IRQ_TWO = 4;
   localparam int IRQ_HIGH = 5;
   localparam int IRQ_LOW = 6;
   localparam int IRQ_CHANGE = 7;
   localparam int WCMD_CLEAR = 0;
   localparam int WCMD_SLEEP = 1;
   localparam int PRE_TIMER = 0;
   localparam int PRE_ONE_CNT = 1;
   localparam int PRE_TWO_CNT = 2;
   localparam int PRE_HIGH = 3;
   localparam int PRE_LOW = 4;
   localparam int PRE_WDOG = 5;
   localparam int PRE_NUM = 6;

   typedef struct packed {
      logic src;
      logic edge_fall;
      logic psc_en;
      logic [2:0] sel;
   } tcpw_timer_ctrl_t;

   typedef struct packed {
      logic en;
      logic [2:0] sel;
   } tcpw_wdog_ctrl_t;

   typedef struct packed {
      logic two_src;
      logic [2:0] two_sel;
      logic one_src;
      logic [2:0] one_sel;
   } tcpw_cnt_ctrl_t;

   typedef struct packed {
      logic low_src;
      logic [2:0] low_sel;
      logic high_src;
      logic [2:0] high_sel;
   } tcpw_pw_ctrl_t;

   typedef struct packed {
      logic ir_en;
      logic low_en;
      logic high_en;
      logic two_en;
      logic one_en;
   } tcpw_run_ctrl_t;

   // scale codes 0..7 mean 1:2..1:256
   function automatic logic [SHIFT_W-1:0] tcpw_scale_shift(
      input logic [2:0] sel);
      return {1'b0, sel} + 4'h1;
   endfunction : tcpw_scale_shift

   function automatic logic [PRE_W-1:0] tcpw_ratio_mask(
      input logic [SHIFT_W-1:0] sh);
      logic [PRE_W:0] m;
      m = (9'h001 << sh) - 9'h001;
      return m[PRE_W-1:0];
   endfunction : tcpw_ratio_mask

   // returns {underflow, next count}
   function automatic logic [8:0] tcpw_down_step(
      input logic [7:0] cnt,
      input logic [7:0] preset,
      input logic tick);
      logic [8:0] r;
      r = {1'b0, cnt};
      if (tick) begin
         r = (cnt == 8'h00) ? {1'b1, preset} : {1'b0, cnt - 8'h01};
      end
      return r;
   endfunction : tcpw_down_step
endpackage : tcpw_pkg

// [common/tcpw_pre_if.sv]
// link between the timer core and one of its prescalers
`timescale 1ns/1ns
`default_nettype none
interface tcpw_pre_if import tcpw_pkg::*; ();
   logic en;
   logic clr;
   logic [SHIFT_W-1:0] shift;
   logic tick;
   modport pre (input en, input clr, input shift, output tick);
   modport user (output en, output clr, output shift, input tick);
endinterface : tcpw_pre_if
`default_nettype wire

// [src/tcpw_prescaler.sv]
// 8-bit prescaler dividing an enable by a power of two
`timescale 1ns/1ns
`default_nettype none
module tcpw_prescaler import tcpw_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   tcpw_pre_if.pre p
);
   typedef struct packed {
      logic [PRE_W-1:0] cnt;
   } tcpw_pre_state_t;

   tcpw_pre_state_t s_reg;
   tcpw_pre_state_t s_next;
   logic [PRE_W-1:0] mask;

   // shift 0 gives an empty mask, i.e. straight through
   assign mask = tcpw_ratio_mask(p.shift);
   assign p.tick = p.en && !p.clr && ((s_reg.cnt & mask) == mask);

   always_comb begin
      s_next = s_reg;
      if (p.clr) begin
         s_next.cnt = '0;
      end else if (p.en) begin
         s_next.cnt = s_reg.cnt + PRE_ONE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   a_clear_zeroes: assert property (@(posedge pclk) disable iff (!presetn)
      p.clr |=> s_reg.cnt == '0)
      else $error("prescaler not cleared");
   a_tick_mask: assert property (@(posedge pclk) disable iff (!presetn)
      p.tick |=> (s_reg.cnt & mask) == '0 || p.shift != $past(p.shift))
      else $error("prescaler tick off its ratio");
endmodule : tcpw_prescaler
`default_nettype wire

// [src/tcpw_timer_top.sv]
// timer counter, down counters, pulse width timers and watchdog
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tcpw_timer_top import tcpw_pkg::*; #(
   parameter int unsigned WDT_CYCLES = WDT_BASE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cycle_clock_option,
   input wire logic sub_oscillator_clock,
   input wire logic counter_pin,
   input wire logic ext_zero_event,
   input wire logic ext_one_event,
   input wire logic input_change_event,
   output logic irq,
   output logic ir_out,
   output logic watchdog_reset
);
   localparam int WCW = $clog2(WDT_CYCLES + 1);
   localparam logic [WCW-1:0] WDT_LAST = WCW'(WDT_CYCLES - 1);
   localparam logic [WCW-1:0] WDT_STEP = WCW'(1);

   typedef struct packed {
      logic [1:0] instr_div;
      logic [7:0] timer_count;
      tcpw_timer_ctrl_t timer_ctrl;
      tcpw_wdog_ctrl_t wdog_ctrl;
      tcpw_cnt_ctrl_t cnt_ctrl;
      tcpw_pw_ctrl_t pw_ctrl;
      tcpw_run_ctrl_t run_ctrl;
      logic [7:0] one_preset;
      logic [7:0] two_preset;
      logic [7:0] high_preset;
      logic [7:0] low_preset;
      logic [7:0] one_count;
      logic [7:0] two_count;
      logic [7:0] high_count;
      logic [7:0] low_count;
      logic [7:0] irq_mask;
      logic [7:0] irq_flags;
      logic pwm_high;
      logic pin_prev;
      logic [WCW-1:0] wdog_base;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic ir_out;
      logic wdog_reset;
   } tcpw_top_state_t;

   tcpw_top_state_t s_reg;
   tcpw_top_state_t s_next;
   logic access;
   logic wr;
   logic instr_en;
   logic rise;
   logic fall;
   logic pin_edge;
   logic base_done;
   logic wdog_clr;
   logic high_phase;
   logic low_phase;
   logic carrier;
   logic one_under;
   logic two_under;
   logic high_under;
   logic low_under;
   logic [7:0] ev;

   tcpw_pre_if pre [PRE_NUM] ();

   for (genvar i = 0; i < PRE_NUM; i++) begin : g_pre
      tcpw_prescaler u_pre (
         .pclk(pclk),
         .presetn(presetn),
         .p(pre[i])
      );
   end

   assign access = psel && penable;
   // a write lands only on the edge where pready is seen high
   assign wr = access && s_reg.pready && pwrite;
   // pclk is the oscillator; one instruction cycle is 2 or 4 of it
   assign instr_en = s_reg.instr_div == (cycle_clock_option ?
      INSTR_SLOW_LAST : INSTR_FAST_LAST);
   // pin edges are seen once per pclk, faster than the cycle clock
   assign rise = counter_pin && !s_reg.pin_prev;
   assign fall = !counter_pin && s_reg.pin_prev;
   assign pin_edge = s_reg.timer_ctrl.edge_fall ? fall : rise;
   assign base_done = s_reg.wdog_ctrl.en && s_reg.wdog_base == WDT_LAST;
   assign wdog_clr = wr && paddr == ADDR_WDOG_CMD &&
      (pwdata[WCMD_CLEAR] || pwdata[WCMD_SLEEP]);
   // pulse timers alternate; a lone timer runs all the time
   assign high_phase = s_reg.pwm_high || !s_reg.run_ctrl.low_en;
   assign low_phase = !s_reg.pwm_high || !s_reg.run_ctrl.high_en;
   assign carrier = s_reg.two_count > (s_reg.two_preset >> 1);

   // timer counter prescaler
   assign pre[PRE_TIMER].en = s_reg.timer_ctrl.src ?
      pin_edge : instr_en;
   assign pre[PRE_TIMER].shift = s_reg.timer_ctrl.psc_en ?
      tcpw_scale_shift(s_reg.timer_ctrl.sel) : 4'h0;
   assign pre[PRE_TIMER].clr = wr && paddr == ADDR_TIMER_COUNT;

   assign pre[PRE_ONE_CNT].en = s_reg.run_ctrl.one_en &&
      (s_reg.cnt_ctrl.one_src ? instr_en : sub_oscillator_clock);
   assign pre[PRE_ONE_CNT].shift = tcpw_scale_shift(s_reg.cnt_ctrl.one_sel);
   assign pre[PRE_ONE_CNT].clr = !s_reg.run_ctrl.one_en;

   assign pre[PRE_TWO_CNT].en = s_reg.run_ctrl.two_en &&
      (s_reg.cnt_ctrl.two_src ? instr_en : sub_oscillator_clock);
   assign pre[PRE_TWO_CNT].shift = tcpw_scale_shift(s_reg.cnt_ctrl.two_sel);
   assign pre[PRE_TWO_CNT].clr = !s_reg.run_ctrl.two_en;

   assign pre[PRE_HIGH].en = s_reg.run_ctrl.high_en && high_phase &&
      (s_reg.pw_ctrl.high_src ? instr_en : sub_oscillator_clock);
   assign pre[PRE_HIGH].shift =
      tcpw_scale_shift(s_reg.pw_ctrl.high_sel);
   assign pre[PRE_HIGH].clr = !s_reg.run_ctrl.high_en;

   assign pre[PRE_LOW].en = s_reg.run_ctrl.low_en && low_phase &&
      (s_reg.pw_ctrl.low_src ? instr_en : sub_oscillator_clock);
   assign pre[PRE_LOW].shift =
      tcpw_scale_shift(s_reg.pw_ctrl.low_sel);
   assign pre[PRE_LOW].clr = !s_reg.run_ctrl.low_en;

   // watchdog scale is 1:1..1:128, one step below the others
   assign pre[PRE_WDOG].en = base_done;
   assign pre[PRE_WDOG].shift = {1'b0, s_reg.wdog_ctrl.sel};
   assign pre[PRE_WDOG].clr = wdog_clr || !s_reg.wdog_ctrl.en;

   always_comb begin
      s_next = s_reg;
      ev = '0;
      s_next.pin_prev = counter_pin;
      s_next.instr_div = instr_en ? 2'h0 : s_reg.instr_div + 2'h1;

      if (pre[PRE_TIMER].tick) begin
         s_next.timer_count = s_reg.timer_count + 8'h01;
      end
      ev[IRQ_TIMER] = pre[PRE_TIMER].tick && s_reg.timer_count == 8'hFF;

      {one_under, s_next.one_count} = tcpw_down_step(s_reg.one_count,
         s_reg.one_preset, pre[PRE_ONE_CNT].tick);
      {two_under, s_next.two_count} = tcpw_down_step(s_reg.two_count,
         s_reg.two_preset, pre[PRE_TWO_CNT].tick);
      {high_under, s_next.high_count} = tcpw_down_step(s_reg.high_count,
         s_reg.high_preset, pre[PRE_HIGH].tick);
      {low_under, s_next.low_count} = tcpw_down_step(s_reg.low_count,
         s_reg.low_preset, pre[PRE_LOW].tick);
      ev[IRQ_ONE] = one_under;
      ev[IRQ_TWO] = two_under;
      ev[IRQ_HIGH] = high_under;
      ev[IRQ_LOW] = low_under;
      ev[IRQ_EXT0] = ext_zero_event;
      ev[IRQ_EXT1] = ext_one_event;
      ev[IRQ_CHANGE] = input_change_event;

      // preset+1 ticks per phase, then hand over to the other timer
      if (high_under && s_reg.run_ctrl.low_en) begin
         s_next.pwm_high = 1'b0;
      end
      if (low_under && s_reg.run_ctrl.high_en) begin
         s_next.pwm_high = 1'b1;
      end

      // no sleep gating: the watchdog base keeps counting
      if (wdog_clr || !s_reg.wdog_ctrl.en || base_done) begin
         s_next.wdog_base = '0;
      end else begin
         s_next.wdog_base = s_reg.wdog_base + WDT_STEP;
      end
      s_next.wdog_reset = pre[PRE_WDOG].tick;

      // apb: setup, then one wait state; read data sampled meanwhile
      s_next.pready = access && !s_reg.pready;
      if (access && !s_reg.pready) begin
         s_next.pslverr = 1'b0;
         case (paddr)
            ADDR_TIMER_COUNT: s_next.prdata = {24'h0, s_reg.timer_count};
            ADDR_TIMER_CTRL: s_next.prdata = {26'h0, s_reg.timer_ctrl};
            ADDR_WDOG_CTRL: s_next.prdata = {28'h0, s_reg.wdog_ctrl};
            ADDR_CNT_CTRL: s_next.prdata = {24'h0, s_reg.cnt_ctrl};
            ADDR_PW_CTRL: s_next.prdata = {24'h0, s_reg.pw_ctrl};
            ADDR_ONE_PRESET: s_next.prdata = {24'h0, s_reg.one_count};
            ADDR_TWO_PRESET: s_next.prdata = {24'h0, s_reg.two_count};
            ADDR_HIGH_PRESET: s_next.prdata = {24'h0, s_reg.high_count};
            ADDR_LOW_PRESET: s_next.prdata = {24'h0, s_reg.low_count};
            ADDR_IRQ_MASK: s_next.prdata = {24'h0, s_reg.irq_mask};
            ADDR_IRQ_FLAGS: s_next.prdata = {24'h0, s_reg.irq_flags};
            ADDR_RUN_CTRL: s_next.prdata = {27'h0, s_reg.run_ctrl};
            ADDR_WDOG_CMD: s_next.prdata = 32'h0;
            default: begin
               s_next.prdata = 32'h0;
               s_next.pslverr = 1'b1;
            end
         endcase
      end

      // register writes override any count step in the same cycle
      if (wr) begin
         case (paddr)
            ADDR_TIMER_COUNT: s_next.timer_count = pwdata[7:0];
            ADDR_TIMER_CTRL: s_next.timer_ctrl =
               tcpw_timer_ctrl_t'(pwdata[$bits(tcpw_timer_ctrl_t)-1:0]);
            ADDR_WDOG_CTRL: s_next.wdog_ctrl =
               tcpw_wdog_ctrl_t'(pwdata[$bits(tcpw_wdog_ctrl_t)-1:0]);
            ADDR_CNT_CTRL: s_next.cnt_ctrl = tcpw_cnt_ctrl_t'(pwdata[7:0]);
            ADDR_PW_CTRL: s_next.pw_ctrl = tcpw_pw_ctrl_t'(pwdata[7:0]);
            ADDR_ONE_PRESET: begin
               s_next.one_preset = pwdata[7:0];
               s_next.one_count = pwdata[7:0];
            end
            ADDR_TWO_PRESET: begin
               s_next.two_preset = pwdata[7:0];
               s_next.two_count = pwdata[7:0];
            end
            ADDR_HIGH_PRESET: begin
               s_next.high_preset = pwdata[7:0];
               s_next.high_count = pwdata[7:0];
            end
            ADDR_LOW_PRESET: begin
               s_next.low_preset = pwdata[7:0];
               s_next.low_count = pwdata[7:0];
            end
            ADDR_IRQ_MASK: s_next.irq_mask = pwdata[7:0];
            ADDR_IRQ_FLAGS: s_next.irq_flags = s_reg.irq_flags &
               ~pwdata[7:0];
            ADDR_RUN_CTRL: s_next.run_ctrl =
               tcpw_run_ctrl_t'(pwdata[$bits(tcpw_run_ctrl_t)-1:0]);
            default: begin
            end
         endcase
      end
      // a new event beats a clear in the same cycle
      s_next.irq_flags = s_next.irq_flags | ev;
      s_next.irq = |(s_next.irq_flags & s_next.irq_mask);

      if (s_reg.run_ctrl.ir_en) begin
         s_next.ir_out = s_reg.pwm_high && carrier &&
            s_reg.run_ctrl.two_en;
      end else begin
         s_next.ir_out = s_reg.pwm_high &&
            (s_reg.run_ctrl.high_en || s_reg.run_ctrl.low_en);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign irq = s_reg.irq;
   assign ir_out = s_reg.ir_out;
   assign watchdog_reset = s_reg.wdog_reset;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_one_reload: assert property (one_under &&
      !(wr && paddr == ADDR_ONE_PRESET) |=> s_reg.one_count ==
      s_reg.one_preset && s_reg.irq_flags[IRQ_ONE])
      else $error("first counter did not reload");
   a_two_reload: assert property (two_under &&
      !(wr && paddr == ADDR_TWO_PRESET) |=> s_reg.two_count ==
      $past(s_reg.two_preset))
      else $error("second counter did not reload");
   a_high_handover: assert property (high_under && s_reg.run_ctrl.low_en
      |=> !s_reg.pwm_high ##1 !s_reg.ir_out)
      else $error("high phase did not end");
   a_low_handover: assert property (low_under && s_reg.run_ctrl.high_en
      |=> s_reg.pwm_high)
      else $error("low phase did not end");
   a_timer_step: assert property (pre[PRE_TIMER].tick && !wr |=>
      s_reg.timer_count == $past(s_reg.timer_count) + 8'h01)
      else $error("timer counter missed a step");
   a_irq_gate: assert property (s_reg.irq_flags[IRQ_ONE] &&
      s_reg.irq_mask[IRQ_ONE] && !wr |=> s_reg.irq)
      else $error("enabled flag gave no request");
   a_wdog_off: assert property (!s_reg.wdog_ctrl.en &&
      $past(!s_reg.wdog_ctrl.en) |-> !watchdog_reset)
      else $error("disabled watchdog fired");
   // the base restarts from zero, so only the edge after the clear is fixed
   a_wdog_clear: assert property (wdog_clr |=>
      s_reg.wdog_base == '0 && !watchdog_reset)
      else $error("watchdog not cleared");
   a_apb_wait: assert property (access && !s_reg.pready |=> pready
      ##1 !pready)
      else $error("apb answer timing broken");

   c_one_under: cover property (one_under ##1 irq);
   c_wdog_fire: cover property (watchdog_reset);
   c_ir_burst: cover property (s_reg.run_ctrl.ir_en && $rose(ir_out));
   c_timer_wrap: cover property (ev[IRQ_TIMER]);
endmodule : tcpw_timer_top
`default_nettype wire

// [bench/tcpw_pin_model.sv]
// partner model: external clock on the timer counter input pin
`timescale 1ns/1ns
`default_nettype none
module tcpw_pin_model (
   input wire logic pclk,
   output logic pin
);
   initial pin = 1'b0;
   // held still between bursts; 4 pclk per phase, no shorter than an instruction of 2 or 4 pclk
   task automatic toggle(input int n);
      repeat (n) begin
         repeat (4) @(posedge pclk);
         pin <= ~pin;
      end
      repeat (4) @(posedge pclk);
   endtask : toggle
endmodule : tcpw_pin_model
`default_nettype wire

// [bench/tcpw_timer_top_tb.sv]
// self-checking bench of the timer, pulse width and watchdog block
`timescale 1ns/1ns
`default_nettype none
module tcpw_timer_top_tb import tcpw_pkg::*;;
   localparam int WDC = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic ir_out;
   logic watchdog_reset;
   logic counter_pin;
   logic cyc_opt = 1'b0;
   logic sub_osc = 1'b0;
   logic [2:0] sub_cnt = 3'h0;
   logic [31:0] rd;
   logic er;
   int errors = 0;
   int n_compared = 0;
   int wd_pulses = 0;
   int cyc = 0;
   always #50 pclk = ~pclk;
   // sub-oscillator enable: one pulse every 5 pclk
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      sub_cnt <= (sub_cnt == 3'h4) ? 3'h0 : sub_cnt + 3'h1;
      sub_osc <= (sub_cnt == 3'h4);
      if (watchdog_reset === 1'b1) wd_pulses <= wd_pulses + 1;
   end
   tcpw_timer_top #(.WDT_CYCLES(WDC)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cycle_clock_option(cyc_opt),
      .sub_oscillator_clock(sub_osc), .counter_pin(counter_pin),
      .ext_zero_event(1'b0), .ext_one_event(1'b0),
      .input_change_event(1'b0), .irq(irq), .ir_out(ir_out),
      .watchdog_reset(watchdog_reset)
   );
   tcpw_pin_model pin_m (.pclk(pclk), .pin(counter_pin));
   task automatic end_of_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string msg);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %0h exp %0h", $time, msg, got,
            exp);
      end
   endtask : chk
   task automatic chk_n(input int got, input int lo, input int hi,
         input string msg);
      n_compared++;
      if (got < lo || got > hi) begin
         errors++;
         $display("CHECK FAILED %0t %s got %0d", $time, msg, got);
      end
   endtask : chk_n
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         errors++;
         end_of_test();
      end
   endtask : apb
   function automatic logic pick(input int w);
      return (w == 0) ? irq : ((w == 1) ? ir_out : watchdog_reset);
   endfunction : pick
   task automatic wait_sig(input int w, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pick(w) !== v && n < 6000);
      if (n >= 6000) begin
         errors++;
         end_of_test();
      end
   endtask : wait_sig
   // period between two flag raises, flag cleared in between
   task automatic irq_period(input logic [7:0] clr, input int exp);
      int t;
      apb(1'b1, ADDR_IRQ_FLAGS, {24'h0, clr});
      wait_sig(0, 1'b0);
      wait_sig(0, 1'b1);
      t = cyc;
      apb(1'b1, ADDR_IRQ_FLAGS, {24'h0, clr});
      wait_sig(0, 1'b0);
      wait_sig(0, 1'b1);
      chk_n(cyc - t, exp, exp, "irq period");
   endtask : irq_period
   task automatic t_regs;
      apb(1'b0, ADDR_IRQ_MASK, 32'h0);
      chk(rd, 32'h0, "mask reset");
      apb(1'b1, ADDR_IRQ_MASK, 32'hA5);
      apb(1'b0, ADDR_IRQ_MASK, 32'h0);
      chk(rd, 32'hA5, "mask rw");
      apb(1'b1, ADDR_PW_CTRL, 32'h5A);
      apb(1'b0, ADDR_PW_CTRL, 32'h0);
      chk(rd, 32'h5A, "pw ctrl rw");
      apb(1'b1, ADDR_LOW_PRESET, 32'h37);
      apb(1'b0, ADDR_LOW_PRESET, 32'h0);
      chk(rd, 32'h37, "preset read");
      apb(1'b0, 8'h3C, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped");
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
   endtask : t_regs
   task automatic t_count;
      apb(1'b1, ADDR_CNT_CTRL, 32'h08);
      apb(1'b1, ADDR_ONE_PRESET, 32'h03);
      apb(1'b1, ADDR_IRQ_MASK, 32'h08);
      apb(1'b1, ADDR_RUN_CTRL, 32'h01);
      irq_period(8'h08, 4 * 2 * 2);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      repeat (40) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "masked irq");
      apb(1'b0, ADDR_IRQ_FLAGS, 32'h0);
      chk(rd & 32'h08, 32'h08, "flag set");
      apb(1'b1, ADDR_RUN_CTRL, 32'h0);
   endtask : t_count
   task automatic t_timer(input logic opt, input logic [7:0] c,
         input int exp);
      cyc_opt <= opt;
      apb(1'b1, ADDR_TIMER_CTRL, {24'h0, c});
      apb(1'b1, ADDR_TIMER_COUNT, 32'h0);
      apb(1'b1, ADDR_IRQ_MASK, 32'h01);
      irq_period(8'h01, exp);
   endtask : t_timer
   task automatic t_pin(input logic [7:0] c, input int n, input int exp);
      apb(1'b1, ADDR_TIMER_CTRL, {24'h0, c});
      apb(1'b1, ADDR_TIMER_COUNT, 32'h0);
      pin_m.toggle(n);
      apb(1'b0, ADDR_TIMER_COUNT, 32'h0);
      chk(rd, exp, "pin count");
   endtask : t_pin
   task automatic t_pwm(input logic [7:0] c, input int hl, input int hh,
         input int ll, input int lh);
      int t;
      int hw;
      int lw;
      apb(1'b1, ADDR_PW_CTRL, {24'h0, c});
      wait_sig(1, 1'b1);
      wait_sig(1, 1'b0);
      repeat (2) begin
         t = cyc;
         wait_sig(1, 1'b1);
         lw = cyc - t;
         t = cyc;
         wait_sig(1, 1'b0);
         hw = cyc - t;
      end
      chk_n(hw, hl, hh, "high width");
      chk_n(lw, ll, lh, "low width");
   endtask : t_pwm
   task automatic t_carrier;
      int t;
      int hits;
      hits = 0;
      apb(1'b1, ADDR_PW_CTRL, 32'h88);
      apb(1'b1, ADDR_CNT_CTRL, 32'h80);
      apb(1'b1, ADDR_TWO_PRESET, 32'h03);
      apb(1'b1, ADDR_HIGH_PRESET, 32'd40);
      apb(1'b1, ADDR_RUN_CTRL, 32'h1E);
      wait_sig(1, 1'b1);
      // a phase boundary spoils at most two of the six periods
      repeat (6) begin
         t = cyc;
         wait_sig(1, 1'b0);
         wait_sig(1, 1'b1);
         if (cyc - t == 16) hits++;
      end
      chk_n(hits, 4, 6, "carrier period");
      apb(1'b1, ADDR_RUN_CTRL, 32'h0);
   endtask : t_carrier
   task automatic wd_period(input logic [7:0] c, input int exp);
      int t;
      apb(1'b1, ADDR_WDOG_CTRL, {24'h0, c});
      wait_sig(2, 1'b1);
      t = cyc;
      wait_sig(2, 1'b0);
      wait_sig(2, 1'b1);
      chk_n(cyc - t, exp, exp, "wdog period");
   endtask : wd_period
   task automatic t_wdclr;
      int n0;
      int t;
      apb(1'b1, ADDR_WDOG_CTRL, 32'h08);
      apb(1'b1, ADDR_WDOG_CMD, 32'h01);
      repeat (2) @(posedge pclk);
      n0 = wd_pulses;
      repeat (8) apb(1'b1, ADDR_WDOG_CMD, 32'h01);
      repeat (8) apb(1'b1, ADDR_WDOG_CMD, 32'h02);
      t = cyc;
      chk_n(wd_pulses - n0, 0, 0, "cleared");
      wait_sig(2, 1'b1);
      chk_n(cyc - t, WDC - 3, WDC + 3, "after sleep");
      apb(1'b1, ADDR_WDOG_CTRL, 32'h00);
      n0 = wd_pulses;
      repeat (60) @(posedge pclk);
      chk_n(wd_pulses - n0, 0, 0, "disabled");
   endtask : t_wdclr
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_count();
      t_timer(1'b0, 8'h00, 256 * 2);
      t_timer(1'b1, 8'h00, 256 * 4);
      t_timer(1'b0, 8'h08, 256 * 2 * 2);
      t_timer(1'b0, 8'h0A, 256 * 8 * 2);
      t_pin(8'h20, 3, 32'h2);
      t_pin(8'h30, 2, 32'h1);
      apb(1'b1, ADDR_HIGH_PRESET, 32'h02);
      apb(1'b1, ADDR_LOW_PRESET, 32'h04);
      apb(1'b1, ADDR_RUN_CTRL, 32'h0C);
      t_pwm(8'h88, 9, 12, 17, 20);
      t_pwm(8'h09, 17, 24, 41, 50);
      t_carrier();
      wd_period(8'h08, WDC);
      wd_period(8'h0A, WDC * 4);
      t_wdclr();
      end_of_test();
   end
endmodule : tcpw_timer_top_tb
`default_nettype wire
